//--- hdl/pesm_pkg.sv
/*
  Shared constants for the event status, mask and sense register block:
  register offsets, bit positions, reset values, valid-bit layouts and the
  serial engine states. Assumes an 8-bit register address and 8-bit data.
*/
package pesm_pkg;

  // ==========================================================
  // register offsets on the serial control port
  localparam logic [7:0] OFF_LIVE_SENSE0   = 8'h07;
  localparam logic [7:0] OFF_CONV_STATUS   = 8'h08;
  localparam logic [7:0] OFF_CONV_MASK     = 8'h09;
  localparam logic [7:0] OFF_CONV_SENSE    = 8'h0a;
  localparam logic [7:0] OFF_BOOST_STATUS  = 8'h0e;
  localparam logic [7:0] OFF_BOOST_MASK    = 8'h0f;
  localparam logic [7:0] OFF_BOOST_SENSE   = 8'h10;
  localparam logic [7:0] OFF_LINREG_STATUS = 8'h11;
  localparam logic [7:0] OFF_LINREG_MASK   = 8'h12;
  localparam logic [7:0] OFF_LINREG_SENSE  = 8'h13;

  // ==========================================================
  // bit positions
  localparam int POS_PWR_BUTTON  = 0;
  localparam int POS_UNDERVOLT   = 1;
  localparam int POS_THERM_LO    = 2;
  localparam int POS_FUSE_SUPPLY = 7;
  localparam int POS_BUCK_1A     = 0;
  localparam int POS_BUCK_1B     = 1;
  localparam int POS_BUCK_2      = 3;
  localparam int POS_BUCK_3A     = 4;
  localparam int POS_BUCK_3B     = 5;
  localparam int POS_BOOST       = 0;
  localparam int POS_FUSE_ERROR  = 7;
  localparam int POS_LDO_LO      = 0;

  // ==========================================================
  // implemented bits and reset values
  localparam logic [7:0] CONV_STAT_BITS   = 8'h3b;
  localparam logic [7:0] CONV_MASK_BITS   = 8'h7f;
  localparam logic [7:0] BOOST_BITS       = 8'h81;
  localparam logic [7:0] LINREG_BITS      = 8'h3f;
  localparam logic [7:0] STAT_RESET       = 8'h00;
  localparam logic [7:0] CONV_MASK_RESET  = 8'h7f;
  localparam logic [7:0] BOOST_MASK_RESET = 8'h81;
  localparam logic [7:0] LINREG_MASK_RESET = 8'h3f;

  // arbitrary neutral default for the 7-bit bus address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } pesm_state_e;

endpackage

//--- hdl/pesm_sync.sv
/*
  Two-stage synchroniser for every asynchronous pin and detector input.
  Assumes inputs may change at any time relative to ref_clk.
*/
`timescale 1ns/100ps
module pesm_sync
(
  input  wire logic       ref_clk,   // block clock
  input  wire logic       nrst,      // async reset, active low
  input  wire logic [21:0] raw,      // packed raw inputs
  pesm_sync_if.src        so         // synchronised levels
);
  import pesm_pkg::*;

  logic [21:0] meta_q;
  logic [21:0] meta_d;
  logic [21:0] sync_q;
  logic [21:0] sync_d;

  always_comb
  begin
    meta_d = raw;
    sync_d = meta_q;
  end

  // idle bus lines reset high so no false start is seen
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_q <= 22'h300000;
      sync_q <= 22'h300000;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign {so.scl, so.sda, so.ldo, so.fuse_err, so.boost, so.buck,
          so.fuse_sup, so.therm, so.uvolt, so.pwr_btn} = sync_q;
endmodule

//--- hdl/pesm_sync_if.sv
/*
  Carrier for synchronised pin and detector levels between the input
  synchroniser and the register core. Single clock domain.
*/
`timescale 1ns/100ps
interface pesm_sync_if;
  logic       scl;        // serial clock level
  logic       sda;        // serial data level
  logic       pwr_btn;    // power button level
  logic       uvolt;      // input undervoltage level
  logic [3:0] therm;      // four thermal threshold levels
  logic       fuse_sup;   // fuse supply pin level
  logic [4:0] buck;       // buck 1A,1B,2,3A,3B over-limit
  logic       boost;      // boost over-limit
  logic       fuse_err;   // fuse error detector
  logic [5:0] ldo;        // six linear regulator over-limit

  modport src (output scl, sda, pwr_btn, uvolt, therm, fuse_sup,
               buck, boost, fuse_err, ldo);
  modport dst (input scl, sda, pwr_btn, uvolt, therm, fuse_sup,
               buck, boost, fuse_err, ldo);
endinterface

//--- hdl/pesm_top.sv
/*
  Event status, mask and sense registers behind a two-wire serial control
  port, with an active-low interrupt output. Assumes the analog detectors
  deliver debounced levels and that the host is the only bus master.
*/
`timescale 1ns/100ps
// Overview of operation
// - sense bit 0 shows power button level
// - sense bit 1 high when input undervoltage
// - sense bits 2-5 show thermal thresholds
// - sense bit 7 shows fuse supply pin
// - buck fault flags latch, write-1 clears
// - buck masks read/write, bits 0-6 reset one
// - buck sense bits show live over-limit
// - boost fault flag bit 0, write-1 clears
// - fuse error flag bit 7, write-1 clears
// - boost and fuse error masks reset one
// - boost sense bit 0 live
// - fuse error sense bit 7 live
// - six regulator flags latch, write-1 clears
// - six regulator masks reset one
// - six regulator sense bits live
// - interrupt low while unmasked flag set
// - flags hold until cleared, set wins
// - unmasking a set flag raises interrupt
module pesm_top
#(
  parameter logic [6:0] DEV_ADDR = pesm_pkg::DEV_ADDR_DEFAULT  // bus address
)
(
  input  wire logic       ref_clk,          // 20 MHz clock
  input  wire logic       nrst,             // async reset, active low
  input  wire logic       scl_in,           // serial clock pin
  input  wire logic       sda_in,           // serial data pin level
  output logic            sda_out,          // serial data drive value
  output logic            sda_oe_n,         // low while pulling data low
  output logic            irq_out_n,        // interrupt, active low
  input  wire logic       power_button_pin, // power button pin
  input  wire logic       input_uvolt_det,  // input at or below 2.8 V
  input  wire logic [3:0] thermal_det,      // 110/120/125/130 exceeded
  input  wire logic       fuse_supply_pin,  // fuse supply pin
  input  wire logic [4:0] buck_fault_det,   // 1A,1B,2,3A,3B over limit
  input  wire logic       boost_fault_det,  // boost over limit
  input  wire logic       fuse_error_det,   // fuse error detected
  input  wire logic [5:0] ldo_fault_det     // regulators 1..6 over limit
);
  import pesm_pkg::*;

  // ==========================================================
  // input synchronisation
  pesm_sync_if sy ();

  pesm_sync u_sync
  (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .raw     ({scl_in, sda_in, ldo_fault_det, fuse_error_det,
               boost_fault_det, buck_fault_det, fuse_supply_pin,
               thermal_det, input_uvolt_det, power_button_pin}),
    .so      (sy.src)
  );

  // ==========================================================
  // live sense views
  logic [7:0] sense0;
  logic [7:0] conv_sense;
  logic [7:0] boost_sense;
  logic [7:0] ldo_sense;

  always_comb
  begin
    sense0                      = 8'h00;
    sense0[POS_PWR_BUTTON]      = sy.pwr_btn;
    sense0[POS_UNDERVOLT]       = sy.uvolt;
    sense0[POS_THERM_LO +: 4]   = sy.therm;
    sense0[POS_FUSE_SUPPLY]     = sy.fuse_sup;
    conv_sense                  = 8'h00;
    conv_sense[POS_BUCK_1A]     = sy.buck[0];
    conv_sense[POS_BUCK_1B]     = sy.buck[1];
    conv_sense[POS_BUCK_2]      = sy.buck[2];
    conv_sense[POS_BUCK_3A]     = sy.buck[3];
    conv_sense[POS_BUCK_3B]     = sy.buck[4];
    boost_sense                 = 8'h00;
    boost_sense[POS_BOOST]      = sy.boost;
    boost_sense[POS_FUSE_ERROR] = sy.fuse_err;
    ldo_sense                   = 8'h00;
    ldo_sense[POS_LDO_LO +: 6]  = sy.ldo;
  end

  // ==========================================================
  // register state
  logic [7:0] conv_stat_q,  conv_stat_d;
  logic [7:0] conv_mask_q,  conv_mask_d;
  logic [7:0] boost_stat_q, boost_stat_d;
  logic [7:0] boost_mask_q, boost_mask_d;
  logic [7:0] ldo_stat_q,   ldo_stat_d;
  logic [7:0] ldo_mask_q,   ldo_mask_d;
  logic [7:0] conv_prev_q;
  logic [7:0] boost_prev_q;
  logic [7:0] ldo_prev_q;
  logic       irq_n_q,      irq_n_d;

  // read mux is used for the first byte and for every auto-increment
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFF_LIVE_SENSE0:   v = sense0;
      OFF_CONV_STATUS:   v = conv_stat_q;
      OFF_CONV_MASK:     v = conv_mask_q;
      OFF_CONV_SENSE:    v = conv_sense;
      OFF_BOOST_STATUS:  v = boost_stat_q;
      OFF_BOOST_MASK:    v = boost_mask_q;
      OFF_BOOST_SENSE:   v = boost_sense;
      OFF_LINREG_STATUS: v = ldo_stat_q;
      OFF_LINREG_MASK:   v = ldo_mask_q;
      OFF_LINREG_SENSE:  v = ldo_sense;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // serial control port
  pesm_state_e st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  sh_q, sh_d;
  logic [7:0]  ptr_q, ptr_d;
  logic        rw_q, rw_d;
  logic        nack_q, nack_d;
  logic        oe_n_q, drv_d;
  logic        scl_p_q, sda_p_q;
  logic        scl_rise, scl_fall, start_seen, stop_seen;
  logic        wr_en;

  assign scl_rise   = sy.scl & ~scl_p_q;
  assign scl_fall   = ~sy.scl & scl_p_q;
  assign start_seen = sy.scl & scl_p_q & sda_p_q & ~sy.sda;
  assign stop_seen  = sy.scl & scl_p_q & ~sda_p_q & sy.sda;

  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    rw_d   = rw_q;
    nack_d = nack_q;
    drv_d  = ~oe_n_q;
    wr_en  = 1'b0;
    if (start_seen)
    begin
      st_d  = ST_ADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
    end
    else if (stop_seen)
    begin
      st_d  = ST_IDLE;
      drv_d = 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_q == ST_ADDR || st_q == ST_REG || st_q == ST_WDATA)
      begin
        sh_d  = {sh_q[6:0], sy.sda};
        cnt_d = cnt_q + 4'h1;
      end
      else if (st_q == ST_RDATA_ACK)
        nack_d = sy.sda;
    end
    else if (scl_fall)
    begin
      unique case (st_q)
        ST_IDLE: ;
        ST_ADDR:
          if (cnt_q == BITS_PER_BYTE)
          begin
            // other addresses are left alone until the next start
            st_d  = (sh_q[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IDLE;
            drv_d = (sh_q[7:1] == DEV_ADDR);
            rw_d  = sh_q[0];
          end
        ST_ADDR_ACK:
        begin
          cnt_d = 4'h0;
          if (rw_q)
          begin
            st_d  = ST_RDATA;
            sh_d  = rd_mux(ptr_q);
            drv_d = ~sh_d[7];
            ptr_d = ptr_q + 8'h01;
          end
          else
          begin
            st_d  = ST_REG;
            drv_d = 1'b0;
          end
        end
        ST_REG:
          if (cnt_q == BITS_PER_BYTE)
          begin
            ptr_d = sh_q;
            st_d  = ST_REG_ACK;
            drv_d = 1'b1;
          end
        ST_REG_ACK, ST_WDATA_ACK:
        begin
          st_d  = ST_WDATA;
          cnt_d = 4'h0;
          drv_d = 1'b0;
        end
        ST_WDATA:
          if (cnt_q == BITS_PER_BYTE)
          begin
            wr_en = 1'b1;
            ptr_d = ptr_q + 8'h01;
            st_d  = ST_WDATA_ACK;
            drv_d = 1'b1;
          end
        ST_RDATA:
          if (cnt_q == 4'h7)
          begin
            st_d  = ST_RDATA_ACK;
            drv_d = 1'b0;
          end
          else
          begin
            sh_d  = {sh_q[6:0], 1'b0};
            drv_d = ~sh_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        ST_RDATA_ACK:
          if (nack_q)
            st_d = ST_IDLE;
          else
          begin
            st_d  = ST_RDATA;
            cnt_d = 4'h0;
            sh_d  = rd_mux(ptr_q);
            drv_d = ~sh_d[7];
            ptr_d = ptr_q + 8'h01;
          end
      endcase
    end
  end

  // ==========================================================
  // flags, masks and interrupt
  logic [7:0] conv_set, boost_set, ldo_set;
  logic [7:0] wr_data;

  always_comb
  begin
    wr_data                    = sh_q;
    conv_set                   = conv_sense & ~conv_prev_q;
    boost_set                  = boost_sense & ~boost_prev_q;
    ldo_set                    = ldo_sense & ~ldo_prev_q;
    conv_stat_d  = (conv_stat_q | conv_set) & CONV_STAT_BITS;
    boost_stat_d = (boost_stat_q | boost_set) & BOOST_BITS;
    ldo_stat_d   = (ldo_stat_q | ldo_set) & LINREG_BITS;
    conv_mask_d  = conv_mask_q;
    boost_mask_d = boost_mask_q;
    ldo_mask_d   = ldo_mask_q;
    if (wr_en)
    begin
      // a clear and a new event in one cycle keep the flag set
      unique case (ptr_q)
        OFF_CONV_STATUS:   conv_stat_d  = ((conv_stat_q & ~wr_data) | conv_set)
                                          & CONV_STAT_BITS;
        OFF_BOOST_STATUS:  boost_stat_d = ((boost_stat_q & ~wr_data) | boost_set)
                                          & BOOST_BITS;
        OFF_LINREG_STATUS: ldo_stat_d   = ((ldo_stat_q & ~wr_data) | ldo_set)
                                          & LINREG_BITS;
        OFF_CONV_MASK:     conv_mask_d  = wr_data & CONV_MASK_BITS;
        OFF_BOOST_MASK:    boost_mask_d = wr_data & BOOST_BITS;
        OFF_LINREG_MASK:   ldo_mask_d   = wr_data & LINREG_BITS;
        default: ;
      endcase
    end
    irq_n_d = ~|((conv_stat_d & ~conv_mask_d) | (boost_stat_d & ~boost_mask_d)
                 | (ldo_stat_d & ~ldo_mask_d));
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q         <= ST_IDLE;
      cnt_q        <= 4'h0;
      sh_q         <= 8'h00;
      ptr_q        <= 8'h00;
      rw_q         <= 1'b0;
      nack_q       <= 1'b0;
      oe_n_q       <= 1'b1;
      scl_p_q      <= 1'b1;
      sda_p_q      <= 1'b1;
      conv_stat_q  <= STAT_RESET;
      boost_stat_q <= STAT_RESET;
      ldo_stat_q   <= STAT_RESET;
      conv_mask_q  <= CONV_MASK_RESET;
      boost_mask_q <= BOOST_MASK_RESET;
      ldo_mask_q   <= LINREG_MASK_RESET;
      conv_prev_q  <= 8'h00;
      boost_prev_q <= 8'h00;
      ldo_prev_q   <= 8'h00;
      irq_n_q      <= 1'b1;
    end
    else
    begin
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      sh_q         <= sh_d;
      ptr_q        <= ptr_d;
      rw_q         <= rw_d;
      nack_q       <= nack_d;
      oe_n_q       <= ~drv_d;
      scl_p_q      <= sy.scl;
      sda_p_q      <= sy.sda;
      conv_stat_q  <= conv_stat_d;
      boost_stat_q <= boost_stat_d;
      ldo_stat_q   <= ldo_stat_d;
      conv_mask_q  <= conv_mask_d;
      boost_mask_q <= boost_mask_d;
      ldo_mask_q   <= ldo_mask_d;
      conv_prev_q  <= conv_sense;
      boost_prev_q <= boost_sense;
      ldo_prev_q   <= ldo_sense;
      irq_n_q      <= irq_n_d;
    end
  end

  assign sda_out   = 1'b0;
  assign sda_oe_n  = oe_n_q;
  assign irq_out_n = irq_n_q;

  // ==========================================================
  // checks
  a_buck_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(sy.buck[2]) |=> conv_stat_q[POS_BUCK_2])
    else $error("buck 2 fault edge not latched");
  a_boost_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(sy.boost) |=> boost_stat_q[POS_BOOST])
    else $error("boost fault edge not latched");
  a_fuse_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(sy.fuse_err) |=> boost_stat_q[POS_FUSE_ERROR])
    else $error("fuse error edge not latched");
  a_flag_holds: assert property (@(posedge ref_clk) disable iff (!nrst)
    ldo_stat_q[0] && !(wr_en && ptr_q == OFF_LINREG_STATUS) |=> ldo_stat_q[0])
    else $error("regulator flag dropped without a clear");
  a_set_wins_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_en && ptr_q == OFF_CONV_STATUS && conv_set[0] |=> conv_stat_q[0] ##1 !irq_out_n
      || conv_mask_q[0])
    else $error("event lost during clear");
  a_ldo_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
    wr_en && ptr_q == OFF_LINREG_STATUS && sh_q[3] && !ldo_set[3] |=> !ldo_stat_q[3])
    else $error("regulator flag not cleared by write one");
  a_irq_asserts: assert property (@(posedge ref_clk) disable iff (!nrst)
    (|(boost_stat_q & ~boost_mask_q)) |-> !irq_out_n)
    else $error("interrupt not asserted for unmasked flag");
  a_irq_releases: assert property (@(posedge ref_clk) disable iff (!nrst)
    ((conv_stat_q | boost_stat_q | ldo_stat_q) == 8'h00) |-> irq_out_n)
    else $error("interrupt low with no flag set");
  a_unmask_raises: assert property (@(posedge ref_clk) disable iff (!nrst)
    $fell(conv_mask_q[1]) && conv_stat_q[1] |-> !irq_out_n)
    else $error("unmasking a set flag did not raise interrupt");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
    conv_stat_q[2] == 1'b0 && conv_stat_q[7:6] == 2'b00 && ldo_mask_q[7:6] == 2'b00)
    else $error("unused bit set");
  a_sense_live: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(power_button_pin) |-> ##2 sense0[POS_PWR_BUTTON])
    else $error("power button level not shown");
endmodule

//--- sim/pesm_host.sv
/*
  Host model: a bit-level master on the two-wire control port.
  Assumes a pull-up on the data wire, resolved by the testbench from all
  parties' drives; the master only ever pulls low or releases.
*/
`timescale 1ns/100ps
module pesm_host
#(
  parameter logic [6:0] DEV_ADDR = pesm_pkg::DEV_ADDR_DEFAULT  // target address
)
(
  input  wire logic ref_clk,   // block clock
  input  wire logic sda_line,  // resolved data wire
  output logic      scl,       // serial clock
  output logic      sda_low    // high while pulling data low
);
  // well above the four-cycle minimum per phase, so the synchroniser keeps up
  localparam int HALF = 10;

  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // ==========================================================
  // bit and byte level
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // scl is already low here except from idle; data released first
  task automatic start();
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask

  // data moves a little after the scl fall so both never change together
  task automatic put_bit(input logic b, output logic seen);
    tick(2);
    sda_low = ~b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    seen = sda_line;
    scl = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(last, s);
  endtask

  // ==========================================================
  // register transfers
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    put_byte({DEV_ADDR, 1'b0}, k0);
    put_byte(a, k1);
    put_byte(d, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2;
    start();
    put_byte({DEV_ADDR, 1'b0}, k0);
    put_byte(a, k1);
    start();
    put_byte({DEV_ADDR, 1'b1}, k2);
    get_byte(1'b1, d);
    stop();
    ok = k0 & k1 & k2;
  endtask
endmodule

//--- sim/pmic_event_status_mask_sense_tb.sv
/*
  Self-checking testbench for the event status, mask and sense registers.
  Assumes the host model above and a pull-up on the data wire.
*/
`timescale 1ns/100ps
module pmic_event_status_mask_sense_tb;
  import pesm_pkg::*;

  logic       ref_clk, nrst, scl, sda_low, sda_line, sda_out, sda_oe_n, irq_out_n;
  logic       pb, uv, fsup, boost, ferr;
  logic [3:0] therm;
  logic [4:0] buck;
  logic [5:0] ldo;
  int         fails, check_count;

  // negedges from the start of a write to the scl fall that ends its data byte:
  // start 30, two whole bytes of 9 bits at 22 each, then 8 data bits
  localparam int RACE_TICKS = 602;

  assign sda_line = (sda_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  pesm_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq_out_n(irq_out_n),
    .power_button_pin(pb), .input_uvolt_det(uv), .thermal_det(therm),
    .fuse_supply_pin(fsup), .buck_fault_det(buck), .boost_fault_det(boost),
    .fuse_error_det(ferr), .ldo_fault_det(ldo));

  pesm_host u_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // ==========================================================
  // shared tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_host.read_reg(a, d, ok);
    check("read ack", 8'h01, {7'h00, ok});
    check($sformatf("register %h", a), exp, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.write_reg(a, d, ok);
    check("write ack", 8'h01, {7'h00, ok});
  endtask

  // bounded wait; running out of it ends the run
  task automatic irq_is(input logic exp);
    int n;
    n = 0;
    while (irq_out_n !== exp && n < 50)
    begin
      @(negedge ref_clk);
      n++;
    end
    check("irq_out_n", {7'h00, exp}, {7'h00, irq_out_n});
    if (n >= 50)
      close_out();
  endtask

  task automatic drive(input logic [7:0] s0, input logic [4:0] b, input logic [1:0] bf,
                       input logic [5:0] l);
    @(negedge ref_clk);
    {fsup, therm, uv, pb} = {s0[7], s0[5:0]};
    buck  = b;
    {ferr, boost} = bf;
    ldo   = l;
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_reset();
    rd(OFF_CONV_MASK, CONV_MASK_RESET);
    rd(OFF_BOOST_MASK, BOOST_MASK_RESET);
    rd(OFF_LINREG_MASK, LINREG_MASK_RESET);
    rd(OFF_CONV_STATUS, STAT_RESET);
    rd(OFF_LINREG_STATUS, STAT_RESET);
    irq_is(1'b1);
  endtask

  task automatic sc_sense();
    drive(8'hab, 5'b10101, 2'b11, 6'h2d);
    rd(OFF_LIVE_SENSE0, 8'hab);
    rd(OFF_CONV_SENSE, 8'h29);
    rd(OFF_BOOST_SENSE, 8'h81);
    rd(OFF_LINREG_SENSE, 8'h2d);
    drive(8'h14, 5'b01010, 2'b00, 6'h12);
    rd(OFF_LIVE_SENSE0, 8'h14);
    rd(OFF_CONV_SENSE, 8'h12);
    rd(OFF_BOOST_SENSE, 8'h00);
    rd(OFF_LINREG_SENSE, 8'h12);
  endtask

  // sources are gone now, every flag that ever rose must still be there
  task automatic sc_latch();
    drive(8'h00, 5'b00000, 2'b00, 6'h00);
    rd(OFF_CONV_STATUS, 8'h3b);
    rd(OFF_BOOST_STATUS, 8'h81);
    rd(OFF_LINREG_STATUS, 8'h3f);
    irq_is(1'b1);
  endtask

  task automatic sc_unmask();
    wr(OFF_CONV_MASK, 8'h00);
    irq_is(1'b0);
    rd(OFF_CONV_MASK, 8'h00);
    wr(OFF_CONV_STATUS, 8'hff);
    rd(OFF_CONV_STATUS, 8'h00);
    irq_is(1'b1);
    drive(8'h00, 5'b00100, 2'b00, 6'h00);
    irq_is(1'b0);
    rd(OFF_CONV_STATUS, 8'h08);
    wr(OFF_CONV_STATUS, 8'h08);
    irq_is(1'b1);
    wr(OFF_LINREG_MASK, 8'h3e);
    irq_is(1'b0);
    wr(OFF_LINREG_STATUS, 8'h3e);
    irq_is(1'b0);
    rd(OFF_LINREG_STATUS, 8'h01);
    wr(OFF_LINREG_STATUS, 8'h01);
    irq_is(1'b1);
  endtask

  task automatic sc_boost();
    wr(OFF_BOOST_MASK, 8'h80);
    irq_is(1'b0);
    wr(OFF_BOOST_STATUS, 8'h01);
    irq_is(1'b1);
    rd(OFF_BOOST_STATUS, 8'h80);
    wr(OFF_BOOST_STATUS, 8'h80);
    rd(OFF_BOOST_STATUS, 8'h00);
  endtask

  // a new edge lands in the very cycle the clear byte is taken: set must win
  task automatic sc_clear_race();
    drive(8'h00, 5'b00001, 2'b00, 6'h00);
    irq_is(1'b0);
    drive(8'h00, 5'b00000, 2'b00, 6'h00);
    fork
      wr(OFF_CONV_STATUS, 8'h01);
      begin
        repeat (RACE_TICKS) @(negedge ref_clk);
        buck[0] = 1'b1;
      end
    join
    irq_is(1'b0);
    rd(OFF_CONV_STATUS, 8'h01);
    wr(OFF_CONV_STATUS, 8'h01);
    irq_is(1'b1);
  endtask

  // reserved places: read zero, writes have no effect
  task automatic sc_reserved();
    wr(OFF_BOOST_MASK, 8'hff);
    rd(OFF_BOOST_MASK, 8'h81);
    wr(OFF_LINREG_MASK, 8'hff);
    rd(OFF_LINREG_MASK, 8'h3f);
    wr(OFF_CONV_MASK, 8'hff);
    rd(OFF_CONV_MASK, 8'h7f);
    wr(OFF_LIVE_SENSE0, 8'hff);
    rd(OFF_LIVE_SENSE0, 8'h00);
    rd(8'h0b, 8'h00);
    irq_is(1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    fails       = 0;
    check_count = 0;
    nrst        = 1'b0;
    {pb, uv, fsup, boost, ferr} = 5'h00;
    therm = 4'h0;
    buck  = 5'h00;
    ldo   = 6'h00;
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    sc_reset();
    sc_sense();
    sc_latch();
    sc_unmask();
    sc_boost();
    sc_clear_race();
    sc_reserved();
    close_out();
  end
endmodule
